// ---- fsp_pkg.sv ----
// Shared constants for flash self-programming control
package fsp_pkg;
	// Control register offset on the register port
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	// Control register field positions
	localparam int EN_BIT = 0;
	localparam int ERASE_BIT = 1;
	localparam int WRITE_BIT = 2;
	localparam int FUSE_BIT = 3;
	localparam int CLEAR_BIT = 4;
	localparam int CMD_W = 5;
	// Legal low five bit command codes, plus CMD_NONE, the idle value that is not accepted
	localparam logic [4:0] CMD_CLEAR = 5'h11;
	localparam logic [4:0] CMD_FUSE = 5'h09;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_LOAD = 5'h01;
	localparam logic [4:0] CMD_NONE = 5'h00;
	// Pointer values selecting fuse and lock bytes
	localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
	localparam logic [15:0] PTR_LOCK = 16'h0001;
	localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
	localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
	// Instruction windows in cycles after the control write takes effect
	localparam int STORE_WINDOW = 4;
	localparam int LOAD_WINDOW = 3;
	// Erase and write time, and clock period
	localparam longint PROG_TIME_NS = 3700000;
	localparam longint CLK_PERIOD_NS = 40;
	localparam int PROG_CYCLES = int'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Geometry defaults
	localparam int PAGE_WORDS = 16;
	localparam int PAGE_BITS = 7;
	// Erased flash word value
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	// Main sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BUSY} fsp_state_t;
endpackage : fsp_pkg

// ---- fsp_buf_if.sv ----
// Link between the sequencer and the temporary page buffer
`timescale 1ns/1ps
interface fsp_buf_if #(
	parameter int WORDS = 16
);
	logic load;
	logic clear;
	logic [$clog2(WORDS)-1:0] index;
	logic [15:0] data;
	logic anyLoaded;
	logic [WORDS*16-1:0] contents;
	modport ctl (output load, output clear, output index, output data,
		input anyLoaded, input contents);
	modport buffer (input load, input clear, input index, input data,
		output anyLoaded, output contents);
endinterface : fsp_buf_if

// ---- fsp_page_buffer.sv ----
// Temporary page buffer, one word per location
`timescale 1ns/1ps
module fsp_page_buffer #(
	parameter int WORDS = 16
) (
	input wire logic mclk, // System clock
	input wire logic rst_n, // System reset, clears the buffer
	fsp_buf_if.buffer bus // Load and clear requests
);
	logic [15:0] mem [WORDS];
	logic [15:0] next_mem [WORDS];
	logic anyLoaded;
	logic next_anyLoaded;

	// Clear wins over load; any location may be loaded in any order
	always_comb begin
		next_mem = mem;
		next_anyLoaded = anyLoaded;
		if (bus.clear) begin
			for (int i = 0; i < WORDS; i++) begin
				next_mem[i] = fsp_pkg::ERASED_WORD;
			end
			next_anyLoaded = 1'b0;
		end else if (bus.load) begin
			next_mem[bus.index] = bus.data;
			next_anyLoaded = 1'b1;
		end
	end

	// Buffer storage
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < WORDS; i++) begin
				mem[i] <= fsp_pkg::ERASED_WORD;
			end
			anyLoaded <= 1'b0;
		end else begin
			mem <= next_mem;
			anyLoaded <= next_anyLoaded;
		end
	end

	// Flat view for the flash macro
	always_comb begin
		for (int i = 0; i < WORDS; i++) begin
			bus.contents[i*16 +: 16] = mem[i];
		end
	end
	assign bus.anyLoaded = anyLoaded;
endmodule : fsp_page_buffer

// ---- fsp_op_timer.sv ----
// Erase and write duration timer, kept alive across system reset
`timescale 1ns/1ps
module fsp_op_timer #(
	parameter int CYCLES = 92500
) (
	input wire logic mclk, // System clock
	input wire logic porRst_n, // Power-on reset only
	input wire logic start, // Begin an operation
	input wire logic startWrite, // Operation is a page write
	output logic busy, // Operation running
	output logic done, // Pulse at operation end
	output logic doneWrite // Pulse at end of a page write
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic isWrite;
	logic next_isWrite;
	logic next_done;
	logic next_doneWrite;

	// Count down the programming time
	always_comb begin
		next_count = count;
		next_isWrite = isWrite;
		next_done = 1'b0;
		next_doneWrite = 1'b0;
		if (count != '0) begin
			next_count = count - 1'b1;
			if (count == CW'(1)) begin
				next_done = 1'b1;
				next_doneWrite = isWrite;
			end
		end else if (start) begin
			next_count = CW'(CYCLES);
			next_isWrite = startWrite;
		end
	end

	// Only power-on reset stops a running operation
	always_ff @(posedge mclk or negedge porRst_n) begin
		if (!porRst_n) begin
			count <= '0;
			isWrite <= 1'b0;
			done <= 1'b0;
			doneWrite <= 1'b0;
		end else begin
			count <= next_count;
			isWrite <= next_isWrite;
			done <= next_done;
			doneWrite <= next_doneWrite;
		end
	end

	assign busy = (count != '0);
endmodule : fsp_op_timer

// ---- fsp_self_prog_ctrl.sv ----
// Flash self-programming sequencer with control register
`timescale 1ns/1ps
// Functional notes
// - Code 00000011 then store within four cycles erases page from pointer page field.
// - Core is halted for the whole page erase.
// - Code 00000001 then store within four cycles loads data pair into buffer.
// - Pointer word field selects the buffer location on a load.
// - Buffer clears after page write, on clear-buffer bit write, and on reset.
// - An EEPROM write during page loading discards the whole buffer.
// - Code 00000101 then store within four cycles writes buffer to pointer page.
// - Core is halted for the whole page write.
// - Buffer locations may be loaded in any order.
// - Load instruction addresses bytes, so pointer bit zero selects the byte.
// - While EEPROM write is busy, programming commands and fuse reads are blocked.
// - Pointer 0x0001, fuse-read set, load within three cycles returns lock byte.
// - Fuse-read and enable clear on read, load timeout or store timeout.
// - Pointer 0x0000 with fuse-read returns fuse low byte.
// - Pointer 0x0003 with fuse-read returns fuse high byte.
// - Programmed fuse and lock bits read as zero, unprogrammed as one.
// - A write in progress completes across a system reset.
// - Control writes with illegal low five bits are ignored.
// - Enable clears after store or timeout; stays set through erase or write.
module fsp_self_prog_ctrl #(
	parameter int PAGE_WORDS = fsp_pkg::PAGE_WORDS,
	parameter int PAGE_BITS = fsp_pkg::PAGE_BITS,
	parameter int PROG_CYCLES = fsp_pkg::PROG_CYCLES
) (
	input wire logic mclk, // System clock, 25 MHz
	input wire logic rst_n, // System reset, active low
	input wire logic porRst_n, // Power-on reset, active low
	input wire logic [7:0] regAddr, // Register address
	input wire logic [7:0] regWrData, // Register write data
	input wire logic regWr, // Register write strobe
	input wire logic regRd, // Register read strobe
	output logic [7:0] regRdData, // Read data, cycle after strobe
	input wire logic storeInstr, // Store-program-memory instruction pulse
	input wire logic loadInstr, // Load-program-memory instruction pulse
	input wire logic [15:0] zPtr, // Pointer register pair
	input wire logic [15:0] srcData, // Data register pair R0
	output logic [7:0] loadData, // Fuse or lock byte for the load
	output logic loadHit, // Load answered here, one cycle
	output logic cpuHalt, // Core stall during erase or write
	input wire logic nvmWriteBusy, // EEPROM write in progress
	input wire logic [7:0] fuseLowProg, // Fuse low byte, one = programmed
	input wire logic [7:0] fuseHighProg, // Fuse high byte, one = programmed
	input wire logic [7:0] fuseExtProg, // Fuse extended byte, one = programmed
	input wire logic [7:0] lockProg, // Lock byte, one = programmed
	output logic flashErase, // Erase start pulse to flash macro
	output logic flashWrite, // Write start pulse, data captured then
	output logic [PAGE_BITS-1:0] flashPage, // Target page index
	output logic [PAGE_WORDS*16-1:0] flashData // Buffer contents
);
	localparam int WB = $clog2(PAGE_WORDS);

	// Geometry check
	if (PAGE_WORDS < 2 || (1 << WB) != PAGE_WORDS || WB + PAGE_BITS + 1 > 16
			|| PROG_CYCLES < 2) begin : g_bad
		$error("fsp_self_prog_ctrl: unsupported geometry or timing");
	end

	fsp_buf_if #(.WORDS(PAGE_WORDS)) bufBus ();

	fsp_page_buffer #(.WORDS(PAGE_WORDS)) u_buffer (
		.mclk(mclk),
		.rst_n(rst_n),
		.bus(bufBus)
	);

	logic timerStart;
	logic timerWrite;
	logic opBusy;
	logic opDone;
	logic opDoneWrite;

	fsp_op_timer #(.CYCLES(PROG_CYCLES)) u_timer (
		.mclk(mclk),
		.porRst_n(porRst_n),
		.start(timerStart),
		.startWrite(timerWrite),
		.busy(opBusy),
		.done(opDone),
		.doneWrite(opDoneWrite)
	);

	fsp_pkg::fsp_state_t state;
	fsp_pkg::fsp_state_t next_state;
	logic [fsp_pkg::CMD_W-1:0] cmd;
	logic [fsp_pkg::CMD_W-1:0] next_cmd;
	logic [2:0] winCnt;
	logic [2:0] next_winCnt;
	logic nvmBusyQ;
	logic [7:0] next_regRdData;
	logic [7:0] next_loadData;
	logic next_loadHit;
	logic next_flashErase;
	logic next_flashWrite;
	logic [PAGE_BITS-1:0] next_flashPage;
	logic ctrlWr;
	logic [4:0] wrCode;
	logic wrLegal;
	logic [7:0] ctrlView;

	assign ctrlWr = regWr && (regAddr == fsp_pkg::CTRL_OFFSET);
	assign wrCode = regWrData[fsp_pkg::CMD_W-1:0];

	// Only five codes are accepted
	always_comb begin
		wrLegal = (wrCode == fsp_pkg::CMD_CLEAR) || (wrCode == fsp_pkg::CMD_FUSE)
			|| (wrCode == fsp_pkg::CMD_WRITE) || (wrCode == fsp_pkg::CMD_ERASE)
			|| (wrCode == fsp_pkg::CMD_LOAD);
	end

	// Readable control view; enable shows busy while an operation runs
	always_comb begin
		ctrlView = 8'h00;
		ctrlView[fsp_pkg::CMD_W-1:0] = cmd;
		if (opBusy) begin
			ctrlView[fsp_pkg::EN_BIT] = 1'b1;
		end
	end

	// Command sequencer
	always_comb begin
		next_state = state;
		next_cmd = cmd;
		next_winCnt = winCnt;
		next_loadData = loadData;
		next_loadHit = 1'b0;
		next_flashErase = 1'b0;
		next_flashWrite = 1'b0;
		next_flashPage = flashPage;
		timerStart = 1'b0;
		timerWrite = 1'b0;
		bufBus.load = 1'b0;
		bufBus.clear = 1'b0;
		bufBus.index = zPtr[WB:1];
		bufBus.data = srcData;
		case (state)
			fsp_pkg::ST_IDLE: begin
				if (ctrlWr && wrLegal && !nvmWriteBusy && !opBusy) begin
					if (wrCode == fsp_pkg::CMD_CLEAR) begin
						bufBus.clear = 1'b1;
						next_cmd = fsp_pkg::CMD_LOAD;
					end else begin
						next_cmd = wrCode;
					end
					next_winCnt = '0;
					next_state = fsp_pkg::ST_ARMED;
				end
			end
			fsp_pkg::ST_ARMED: begin
				next_winCnt = winCnt + 3'd1;
				if (storeInstr) begin
					// Store ends the window whatever it does
					next_cmd = fsp_pkg::CMD_NONE;
					next_state = fsp_pkg::ST_IDLE;
					if (nvmWriteBusy) begin
						next_state = fsp_pkg::ST_IDLE;
					end else if (cmd == fsp_pkg::CMD_ERASE) begin
						next_flashErase = 1'b1;
						next_flashPage = zPtr[WB+1 +: PAGE_BITS];
						timerStart = 1'b1;
						next_cmd = cmd;
						next_state = fsp_pkg::ST_BUSY;
					end else if (cmd == fsp_pkg::CMD_WRITE) begin
						next_flashWrite = 1'b1;
						next_flashPage = zPtr[WB+1 +: PAGE_BITS];
						timerStart = 1'b1;
						timerWrite = 1'b1;
						next_cmd = cmd;
						next_state = fsp_pkg::ST_BUSY;
					end else if (cmd == fsp_pkg::CMD_LOAD) begin
						bufBus.load = 1'b1;
					end
				end else if (loadInstr && cmd == fsp_pkg::CMD_FUSE
						&& winCnt < 3'(fsp_pkg::LOAD_WINDOW)) begin
					next_cmd = fsp_pkg::CMD_NONE;
					next_state = fsp_pkg::ST_IDLE;
					if (!nvmWriteBusy) begin
						next_loadHit = 1'b1;
						// Full pointer compare, bit zero picks the byte
						if (zPtr == fsp_pkg::PTR_LOCK) begin
							next_loadData = ~lockProg;
						end else if (zPtr == fsp_pkg::PTR_FUSE_HIGH) begin
							next_loadData = ~fuseHighProg;
						end else if (zPtr == fsp_pkg::PTR_FUSE_EXT) begin
							next_loadData = ~fuseExtProg;
						end else if (zPtr == fsp_pkg::PTR_FUSE_LOW) begin
							next_loadData = ~fuseLowProg;
						end else begin
							next_loadData = 8'hff;
						end
					end
				end else if (cmd == fsp_pkg::CMD_FUSE
						&& winCnt == 3'(fsp_pkg::LOAD_WINDOW - 1)) begin
					next_cmd = fsp_pkg::CMD_NONE;
					next_state = fsp_pkg::ST_IDLE;
				end else if (winCnt == 3'(fsp_pkg::STORE_WINDOW - 1)) begin
					next_cmd = fsp_pkg::CMD_NONE;
					next_state = fsp_pkg::ST_IDLE;
				end
			end
			fsp_pkg::ST_BUSY: begin
				// Enable and command stay visible until the macro is done
				if (opDone) begin
					next_cmd = fsp_pkg::CMD_NONE;
					next_state = fsp_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = fsp_pkg::ST_IDLE;
			end
		endcase
		// End of a page write empties the buffer, even after a reset
		if (opDoneWrite) begin
			bufBus.clear = 1'b1;
		end
		// EEPROM write starting during page loading loses the loads
		if (nvmWriteBusy && !nvmBusyQ && bufBus.anyLoaded) begin
			bufBus.clear = 1'b1;
		end
	end

	// Register read data, one cycle after the strobe
	always_comb begin
		next_regRdData = 8'h00;
		if (regRd && regAddr == fsp_pkg::CTRL_OFFSET) begin
			next_regRdData = ctrlView;
		end
	end

	// Sequencer and output registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= fsp_pkg::ST_IDLE;
			cmd <= fsp_pkg::CMD_NONE;
			winCnt <= 3'h0;
			nvmBusyQ <= 1'b0;
			regRdData <= 8'h00;
			loadData <= 8'h00;
			loadHit <= 1'b0;
			flashErase <= 1'b0;
			flashWrite <= 1'b0;
			flashPage <= '0;
		end else begin
			state <= next_state;
			cmd <= next_cmd;
			winCnt <= next_winCnt;
			nvmBusyQ <= nvmWriteBusy;
			regRdData <= next_regRdData;
			loadData <= next_loadData;
			loadHit <= next_loadHit;
			flashErase <= next_flashErase;
			flashWrite <= next_flashWrite;
			flashPage <= next_flashPage;
		end
	end

	// Core stalls while the timer runs, across system reset
	assign cpuHalt = opBusy;
	assign flashData = bufBus.contents;
endmodule : fsp_self_prog_ctrl

// ---- fsp_checker.sv ----
// Concurrent checks on the self-programming sequencer ports
`timescale 1ns/1ps
module fsp_checker #(
	parameter int PAGE_WORDS = 16,
	parameter int PAGE_BITS = 7,
	parameter int PROG_CYCLES = 20
) (
	input wire logic mclk, // Clock
	input wire logic rst_n, // System reset
	input wire logic porRst_n, // Power-on reset
	input wire logic storeInstr, // Store pulse
	input wire logic loadInstr, // Load pulse
	input wire logic [15:0] zPtr, // Pointer
	input wire logic [7:0] loadData, // Fuse byte
	input wire logic loadHit, // Load answer
	input wire logic cpuHalt, // Core stall
	input wire logic nvmWriteBusy, // EEPROM busy
	input wire logic [7:0] fuseLowProg, // Fuse low
	input wire logic [7:0] fuseHighProg, // Fuse high
	input wire logic [7:0] lockProg, // Lock byte
	input wire logic flashErase, // Erase pulse
	input wire logic flashWrite, // Write pulse
	input wire logic [PAGE_BITS-1:0] flashPage, // Page
	input wire logic [PAGE_WORDS*16-1:0] flashData // Buffer
);
	localparam int WB = $clog2(PAGE_WORDS);
	int haltCnt;
	int next_haltCnt;
	logic lastWrite;
	logic next_lastWrite;
	// Stall length and kind of last operation
	always_comb begin
		next_haltCnt = cpuHalt ? haltCnt + 1 : 0;
		next_lastWrite = flashWrite ? 1'b1 : (flashErase ? 1'b0 : lastWrite);
	end
	always_ff @(posedge mclk or negedge porRst_n) begin
		if (!porRst_n) begin
			haltCnt <= 0;
			lastWrite <= 1'b0;
		end else begin
			haltCnt <= next_haltCnt;
			lastWrite <= next_lastWrite;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_erase_cause: assert property (flashErase |-> $past(storeInstr) && !$past(nvmWriteBusy))
		else $error("erase pulse without store");
	a_write_cause: assert property (flashWrite |-> $past(storeInstr) && !$past(nvmWriteBusy))
		else $error("write pulse without store");
	a_page_field: assert property ((flashErase || flashWrite) |->
		flashPage == PAGE_BITS'($past(zPtr) >> (WB + 1)))
		else $error("page index not from pointer");
	a_halt_follows: assert property (disable iff (!porRst_n)
		(flashErase || flashWrite) |=> cpuHalt)
		else $error("core not halted");
	a_halt_length: assert property (disable iff (!porRst_n)
		$fell(cpuHalt) |-> haltCnt == PROG_CYCLES)
		else $error("halt length wrong");
	a_halt_bound: assert property (disable iff (!porRst_n) haltCnt <= PROG_CYCLES)
		else $error("halt too long");
	a_fuse_cause: assert property (loadHit |-> $past(loadInstr) && !$past(nvmWriteBusy))
		else $error("load answer without load");
	a_lock_value: assert property (loadHit && $past(zPtr) == 16'h0001 |->
		loadData == ~$past(lockProg))
		else $error("lock byte wrong");
	a_fuse_low: assert property (loadHit && $past(zPtr) == 16'h0000 |->
		loadData == ~$past(fuseLowProg))
		else $error("fuse low byte wrong");
	a_fuse_high: assert property (loadHit && $past(zPtr) == 16'h0003 |->
		loadData == ~$past(fuseHighProg))
		else $error("fuse high byte wrong");
	a_buf_cleared: assert property ($fell(cpuHalt) && lastWrite |-> ##[0:1] (&flashData))
		else $error("buffer kept after write");
endmodule : fsp_checker

// ---- fsp_core_model.sv ----
// CPU core model issuing store and load instruction pulses
`timescale 1ns/1ps
module fsp_core_model (
	input wire logic mclk, // Clock
	input wire logic cpuHalt, // Core stall
	output logic storeInstr, // Store pulse
	output logic loadInstr // Load pulse
);
	// Idle at time zero
	initial begin
		storeInstr = 1'b0;
		loadInstr = 1'b0;
	end
	// One pulse in cycle n after the control write
	task automatic issue(input logic isLoad, input int n);
		repeat (n - 1) @(posedge mclk);
		// A halted core issues nothing
		if (cpuHalt !== 1'b1) begin
			if (isLoad) loadInstr <= 1'b1;
			else storeInstr <= 1'b1;
		end
		@(posedge mclk);
		loadInstr <= 1'b0;
		storeInstr <= 1'b0;
	endtask : issue
endmodule : fsp_core_model

// ---- testbench.sv ----
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ps
module testbench;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic porRst_n = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [15:0] zPtr = 16'h0000;
	logic [15:0] srcData = 16'h0000;
	logic nvmWriteBusy = 1'b0;
	logic [7:0] regRdData;
	logic [7:0] loadData;
	logic loadHit, cpuHalt, flashErase, flashWrite, storeInstr, loadInstr;
	logic [6:0] flashPage;
	logic [255:0] flashData;
	logic [255:0] expBuf;
	logic [7:0] fuseExp [4] = '{8'h9d, 8'hfc, 8'hfe, 8'h20};
	// Programmed fuse and lock bits, indexed by pointer value
	logic [7:0] fuseProg [4] = '{8'h62, 8'h03, 8'h01, 8'hdf};
	int error_cnt = 0;
	int samples_checked = 0;
	// Clock, 40 ns period
	always #20 mclk = ~mclk;
	fsp_self_prog_ctrl #(.PAGE_WORDS(16), .PAGE_BITS(7), .PROG_CYCLES(20)) i_dut (
		.mclk(mclk), .rst_n(rst_n), .porRst_n(porRst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.storeInstr(storeInstr), .loadInstr(loadInstr), .zPtr(zPtr), .srcData(srcData),
		.loadData(loadData), .loadHit(loadHit), .cpuHalt(cpuHalt),
		.nvmWriteBusy(nvmWriteBusy), .fuseLowProg(fuseProg[0]), .fuseHighProg(fuseProg[3]),
		.fuseExtProg(fuseProg[2]), .lockProg(fuseProg[1]), .flashErase(flashErase),
		.flashWrite(flashWrite), .flashPage(flashPage), .flashData(flashData));
	fsp_core_model i_core (.mclk(mclk), .cpuHalt(cpuHalt), .storeInstr(storeInstr),
		.loadInstr(loadInstr));
	task automatic end_sim;
		$display("checks=%0d errors=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick;
		@(posedge mclk);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] d);
		@(posedge mclk);
		regWr <= 1'b1;
		regWrData <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		regAddr <= 8'h00;
		#1;
		chk(regRdData, exp);
	endtask : rd
	// Control write, then instruction in cycle n
	task automatic op(input logic [7:0] c, input logic [15:0] p, input int n, input logic ld);
		zPtr <= p;
		wr(c);
		i_core.issue(ld, n);
	endtask : op
	task automatic waitFree;
		for (int i = 0; i < 60 && cpuHalt !== 1'b0; i++) tick();
		if (cpuHalt !== 1'b0) begin
			error_cnt++;
			end_sim();
		end
	endtask : waitFree
	// Command bits and enable stay readable while the operation runs
	task automatic waitHalt(input logic [7:0] busyView);
		repeat (2) @(posedge mclk);
		#1;
		chk(cpuHalt, 1'b1);
		rd(8'h00, busyView);
		waitFree();
		rd(8'h00, 8'h00);
	endtask : waitHalt
	initial begin
		expBuf = '1;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		porRst_n <= 1'b1;
		tick();
		chk(flashData, expBuf);
		rd(8'h00, 8'h00);
		rd(8'h05, 8'h00);
		// Loads out of order, pointer bit zero set on the first
		srcData <= 16'h1234;
		op(8'h01, 16'h0007, 1, 1'b0);
		srcData <= 16'habcd;
		op(8'h01, 16'h0000, 4, 1'b0);
		tick();
		expBuf[48 +: 16] = 16'h1234;
		expBuf[0 +: 16] = 16'habcd;
		chk(flashData, expBuf);
		// Late store and illegal code change nothing
		op(8'h01, 16'h000a, 5, 1'b0);
		op(8'h07, 16'h000c, 1, 1'b0);
		tick();
		chk(flashData, expBuf);
		wr(8'h01);
		rd(8'h00, 8'h01);
		repeat (4) tick();
		rd(8'h00, 8'h00);
		// EEPROM write discards loads and blocks commands
		nvmWriteBusy <= 1'b1;
		tick();
		tick();
		expBuf = '1;
		chk(flashData, expBuf);
		op(8'h01, 16'h0004, 1, 1'b0);
		op(8'h09, 16'h0001, 1, 1'b1);
		#1 chk(loadHit, 1'b0);
		tick();
		chk(flashData, expBuf);
		nvmWriteBusy <= 1'b0;
		// Fuse and lock bytes read back inverted
		for (int i = 0; i < 4; i++) begin
			op(8'h09, 16'(i), 1, 1'b1);
			#1 chk(loadHit, 1'b1);
			chk(loadData, fuseExp[i]);
			rd(8'h00, 8'h00);
		end
		// Changed lock byte, load in the last cycle of the window
		fuseProg[1] <= 8'h00;
		op(8'h09, 16'h0001, 3, 1'b1);
		#1 chk(loadHit, 1'b1);
		chk(loadData, 8'hff);
		// Store after a fuse-read arm ends it, a later load misses
		op(8'h09, 16'h0001, 1, 1'b0);
		i_core.issue(1'b1, 2);
		#1 chk(loadHit, 1'b0);
		op(8'h09, 16'h0001, 4, 1'b1);
		#1 chk(loadHit, 1'b0);
		// Clear-buffer write drops a loaded word
		srcData <= 16'h5a5a;
		op(8'h01, 16'h0004, 2, 1'b0);
		tick();
		chk(flashData[47:32], 16'h5a5a);
		wr(8'h11);
		repeat (5) tick();
		chk(flashData, expBuf);
		// Erase, load one word, then write one page
		op(8'h03, 16'h00a0, 2, 1'b0);
		waitHalt(8'h03);
		chk(flashData, expBuf);
		srcData <= 16'h0f0f;
		op(8'h01, 16'h0000, 1, 1'b0);
		op(8'h05, 16'h00a0, 3, 1'b0);
		waitHalt(8'h05);
		chk(flashPage, 7'h05);
		chk(flashData, expBuf);
		// EEPROM write rising while armed makes the store do nothing
		zPtr <= 16'h0060;
		wr(8'h03);
		nvmWriteBusy <= 1'b1;
		i_core.issue(1'b0, 2);
		#1 chk(flashErase, 1'b0);
		chk(cpuHalt, 1'b0);
		nvmWriteBusy <= 1'b0;
		// Reset during an erase leaves it running
		op(8'h03, 16'h0040, 1, 1'b0);
		repeat (3) tick();
		rst_n <= 1'b0;
		tick();
		rst_n <= 1'b1;
		tick();
		chk(cpuHalt, 1'b1);
		rd(8'h00, 8'h01);
		waitFree();
		end_sim();
	end
endmodule : testbench
bind fsp_self_prog_ctrl fsp_checker #(.PAGE_WORDS(PAGE_WORDS), .PAGE_BITS(PAGE_BITS),
	.PROG_CYCLES(PROG_CYCLES)) i_chk (.mclk(mclk), .rst_n(rst_n), .porRst_n(porRst_n),
	.storeInstr(storeInstr), .loadInstr(loadInstr), .zPtr(zPtr), .loadData(loadData),
	.loadHit(loadHit), .cpuHalt(cpuHalt), .nvmWriteBusy(nvmWriteBusy),
	.fuseLowProg(fuseLowProg), .fuseHighProg(fuseHighProg), .lockProg(lockProg),
	.flashErase(flashErase), .flashWrite(flashWrite), .flashPage(flashPage),
	.flashData(flashData));
